// ==== core/cca_arith_unit.sv ====
`include "cca_regs.svh"
// Function
// - carry out is a if equal, else cin
// - initialization section plus chained main section
// - init cell holds at most one sum bit
// - seed from chain carry, in1, inverted in3, or constant
// - top section gives carry and overflow
// - final carry examined past overflow cell
// - bypassed top stage recomputed for overflow
// - subtract inverts b into carry and sum
// - carry is active low borrow in subtract
// - subtract lsb variant forces carry high
// - add/sub select drives both stage and generator
// - increment gates b, high carry increments
// - increment init seeds asserted carry
// - decrement gates b, low carry decrements
// - up/down carry polarity follows mode
// - dual-bit up/down base asserts carry
// - two's complement is decrement then invert
// - carry stage independent of generators
// - b polarity control and b gate
module cca_arith_unit #(
    parameter int WIDTH = `CCA_WIDTH
) (
    // clock and reset
    input  wire logic             SYS_CLK_IN,
    input  wire logic             SYS_RST_IN,
    // operands
    input  wire logic [WIDTH-1:0] OPA_IN,
    input  wire logic [WIDTH-1:0] OPB_IN,
    // function and mode controls
    input  wire logic [2:0]       FUNC_IN,
    input  wire logic             ADD_SUB_IN,     // 1 adds, 0 subtracts (gen input three)
    input  wire logic             UP_DOWN_IN,     // 1 counts up, 0 down
    // seed controls
    input  wire logic [1:0]       SEED_SEL_IN,
    input  wire logic             CARRY_IN,       // chain carry from another stage
    input  wire logic             SEED_IN1_IN,
    input  wire logic             SEED_CONST_IN,
    input  wire logic             FORCE_LSB_IN,   // force lsb carry: high for sub/inc, low for dec/twos, per mode for up/down and add/sub
    // results
    output logic [WIDTH-1:0]      SUM_OUT,
    output logic                  CARRY_OUT,
    output logic                  OVF_OUT
);
    cca_pkg::cca_state_s     state_reg;     // registered results
    cca_pkg::cca_state_s     state_next;    // next results
    cca_pkg::cca_stage_cfg_s cfg;           // stage configuration
    logic                    sum_inv;       // output inversion for two's complement
    logic                    seed_raw;      // seed from the init cell
    logic                    seed;          // carry entering bit 0
    logic                    in3;           // value on generator input three
    logic [WIDTH:0]          chain;         // carry chain, chain[i] into bit i
    logic [WIDTH-1:0]        sum;           // combinational sum bits
    logic                    top_cout;      // recomputed top carry
    logic                    b_top;         // top b after controls

    // add/sub or up/down select feeds input three of each generator
    assign in3 = (FUNC_IN == `CCA_FN_UPDOWN) ? UP_DOWN_IN : ADD_SUB_IN;

    // decode stage polarity and gating per function
    always_comb begin
        cfg     = '0;
        sum_inv = 1'b0;
        unique case (FUNC_IN)
            `CCA_FN_ADD:    cfg = '{b_invert: 1'b0, b_gate: 1'b0};
            `CCA_FN_SUB:    cfg = '{b_invert: 1'b1, b_gate: 1'b0};
            `CCA_FN_ADD_OR_SUB_CELLS: cfg = '{b_invert: ~in3, b_gate: 1'b0};
            `CCA_FN_INC:    cfg = '{b_invert: 1'b0, b_gate: 1'b1};
            `CCA_FN_DEC:    cfg = '{b_invert: 1'b1, b_gate: 1'b1};
            `CCA_FN_UPDOWN: cfg = '{b_invert: ~in3, b_gate: 1'b1};
            `CCA_FN_TWOS: begin
                cfg     = '{b_invert: 1'b1, b_gate: 1'b1};
                sum_inv = 1'b1;
            end
            default:        cfg = '0;
        endcase
    end

    // initialization cell selects the chain seed
    cca_seed u_seed (
        .src_in   (CARRY_IN),
        .sel_in   (SEED_SEL_IN),
        .in1_in   (SEED_IN1_IN),
        .in3_in   (in3),
        .const_in (SEED_CONST_IN),
        .seed_out (seed_raw)
    );

    // fixed lsb variants: sub/inc seed high, dec/twos seed low, updown and add/sub per mode
    always_comb begin
        seed = seed_raw;
        if (FORCE_LSB_IN) begin
            unique case (FUNC_IN)
                `CCA_FN_SUB:    seed = 1'b1;
                `CCA_FN_INC:    seed = 1'b1;
                `CCA_FN_DEC:    seed = 1'b0;
                `CCA_FN_TWOS:   seed = 1'b0;
                `CCA_FN_UPDOWN: seed = in3;
                `CCA_FN_ADD_OR_SUB_CELLS: seed = ~in3;
                default:        seed = seed_raw;
            endcase
        end
    end

    assign chain[0] = seed;

    // linear ripple cascade of carry stages
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            cca_carry_stage u_stage (
                .a_in       (OPA_IN[gi]),
                .b_in       (OPB_IN[gi]),
                .cin_in     (chain[gi]),
                .cfg_in     (cfg),
                .sum_inv_in (sum_inv),
                .sum_out    (sum[gi]),
                .cout_out   (chain[gi+1])
            );
        end
    endgenerate

    // top carry recomputed from operand bits as extra cell would
    assign b_top    = (OPB_IN[WIDTH-1] & ~cfg.b_gate) ^ cfg.b_invert;
    assign top_cout = (OPA_IN[WIDTH-1] == b_top) ? OPA_IN[WIDTH-1] : chain[WIDTH-1];

    // capture results; overflow is final carry xor carry into top bit
    always_comb begin
        state_next              = state_reg;
        state_next.sum          = '0;
        state_next.sum[WIDTH-1:0] = sum;
        state_next.carry        = top_cout;
        state_next.ovf          = top_cout ^ chain[WIDTH-1];
        state_next.msb_carry_in = chain[WIDTH-1];
    end

    // result register
    always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign SUM_OUT   = state_reg.sum[WIDTH-1:0];
    assign CARRY_OUT = state_reg.carry;
    assign OVF_OUT   = state_reg.ovf;

    // reference arithmetic for checks
    logic [WIDTH:0] ref_add;
    assign ref_add = {1'b0, OPA_IN} + {1'b0, OPB_IN} + {{WIDTH{1'b0}}, seed};

    // reference values for the subtract, add/sub, seed and forced-seed checks
    logic [WIDTH:0]   ref_sub;       // a plus inverted b plus seed
    logic [WIDTH-1:0] b_sel;         // b as the add/sub select leaves it
    logic [WIDTH:0]   ref_add_or_sub_cells;    // a plus selected b plus seed
    logic [WIDTH-1:0] ab_sum;        // plain a plus b
    logic [WIDTH-1:0] ab_diff;       // plain a minus b
    logic [WIDTH-1:0] one_w;         // the value one at datapath width
    assign ref_sub    = {1'b0, OPA_IN} + {1'b0, ~OPB_IN} + {{WIDTH{1'b0}}, seed};
    assign b_sel      = ADD_SUB_IN ? OPB_IN : ~OPB_IN;
    assign ref_add_or_sub_cells = {1'b0, OPA_IN} + {1'b0, b_sel} + {{WIDTH{1'b0}}, seed};
    assign ab_sum     = OPA_IN + OPB_IN;
    assign ab_diff    = OPA_IN - OPB_IN;
    assign one_w      = {{(WIDTH-1){1'b0}}, 1'b1};

    AST_ADD_SUM: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
        (FUNC_IN == `CCA_FN_ADD) |=> SUM_OUT == $past(ref_add[WIDTH-1:0]))
        else $error("add sum wrong");
    AST_ADD_CARRY: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
        (FUNC_IN == `CCA_FN_ADD) |=> CARRY_OUT == $past(ref_add[WIDTH]))
        else $error("add carry wrong");
    AST_SUB: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
        (FUNC_IN == `CCA_FN_SUB) |=> SUM_OUT == $past(OPA_IN - OPB_IN - {{(WIDTH-1){1'b0}}, ~seed}))
        else $error("sub result wrong");
    AST_INC: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
        (FUNC_IN == `CCA_FN_INC) |=> SUM_OUT == $past(OPA_IN + {{(WIDTH-1){1'b0}}, seed}))
        else $error("inc result wrong");
    AST_DEC: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
        (FUNC_IN == `CCA_FN_DEC) |=> SUM_OUT == $past(OPA_IN - {{(WIDTH-1){1'b0}}, ~seed}))
        else $error("dec result wrong");
    AST_TWOS: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
        (FUNC_IN == `CCA_FN_TWOS && !seed) |=> SUM_OUT == $past(~OPA_IN + 1'b1))
        else $error("twos complement wrong");
    AST_OVF: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
        (FUNC_IN == `CCA_FN_ADD) |=> OVF_OUT ==
        $past((OPA_IN[WIDTH-1] == OPB_IN[WIDTH-1]) && (ref_add[WIDTH-1] != OPA_IN[WIDTH-1])))
        else $error("overflow wrong");
    AST_SUB_LSB: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
        (FUNC_IN == `CCA_FN_SUB && FORCE_LSB_IN) |=> SUM_OUT == $past(OPA_IN - OPB_IN))
        else $error("forced no-borrow wrong");
    AST_UPDOWN: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
        (FUNC_IN == `CCA_FN_UPDOWN && FORCE_LSB_IN && UP_DOWN_IN) |=> SUM_OUT == $past(OPA_IN + 1'b1))
        else $error("up count wrong");

    // subtract carry is the raw chain carry, high means no borrow
    AST_SUB_CARRY: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
        (FUNC_IN == `CCA_FN_SUB) |=> CARRY_OUT == $past(ref_sub[WIDTH]))
        else $error("sub carry wrong");

    // subtract overflow uses the inverted b, same definition as add
    AST_SUB_OVF: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
        (FUNC_IN == `CCA_FN_SUB) |=> OVF_OUT == $past((OPA_IN[WIDTH-1] != OPB_IN[WIDTH-1])
        && (ref_sub[WIDTH-1] != OPA_IN[WIDTH-1])))
        else $error("sub overflow wrong");

    // add/sub select flips b in stage and generator together
    AST_ADD_OR_SUB_CELLS_SUM: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
        (FUNC_IN == `CCA_FN_ADD_OR_SUB_CELLS) |=> SUM_OUT == $past(ref_add_or_sub_cells[WIDTH-1:0]))
        else $error("add_or_sub_cells sum wrong");

    // add/sub carry follows the selected b polarity
    AST_ADD_OR_SUB_CELLS_CARRY: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
        (FUNC_IN == `CCA_FN_ADD_OR_SUB_CELLS) |=> CARRY_OUT == $past(ref_add_or_sub_cells[WIDTH]))
        else $error("add_or_sub_cells carry wrong");

    // add/sub overflow on the selected b
    AST_ADD_OR_SUB_CELLS_OVF: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
        (FUNC_IN == `CCA_FN_ADD_OR_SUB_CELLS) |=> OVF_OUT == $past((OPA_IN[WIDTH-1] == b_sel[WIDTH-1])
        && (ref_add_or_sub_cells[WIDTH-1] != OPA_IN[WIDTH-1])))
        else $error("add_or_sub_cells overflow wrong");

    // forced add/sub seed is unasserted in both modes
    AST_ADD_OR_SUB_CELLS_FORCE: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
        (FUNC_IN == `CCA_FN_ADD_OR_SUB_CELLS && FORCE_LSB_IN) |=> SUM_OUT == $past(ADD_SUB_IN ? ab_sum : ab_diff))
        else $error("add_or_sub_cells forced seed wrong");

    // increment carries out only when a is all ones and carry is high
    AST_INC_CARRY: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
        (FUNC_IN == `CCA_FN_INC) |=> CARRY_OUT == $past((&OPA_IN) && seed))
        else $error("inc carry wrong");

    // increment init cell seeds an asserted carry
    AST_INC_FORCE: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
        (FUNC_IN == `CCA_FN_INC && FORCE_LSB_IN) |=> SUM_OUT == $past(OPA_IN + one_w))
        else $error("inc forced seed wrong");

    // decrement borrows out only from zero with borrow asserted
    AST_DEC_CARRY: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
        (FUNC_IN == `CCA_FN_DEC) |=> CARRY_OUT == $past((|OPA_IN) || seed))
        else $error("dec carry wrong");

    // decrement init cell seeds a low carry
    AST_DEC_FORCE: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
        (FUNC_IN == `CCA_FN_DEC && FORCE_LSB_IN) |=> SUM_OUT == $past(OPA_IN - one_w))
        else $error("dec forced seed wrong");

    // up/down base cell in down mode counts down
    AST_UPDOWN_DOWN: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
        (FUNC_IN == `CCA_FN_UPDOWN && FORCE_LSB_IN && !UP_DOWN_IN) |=> SUM_OUT == $past(OPA_IN - one_w))
        else $error("down count wrong");

    // unasserted carry or borrow passes a in either mode
    AST_UPDOWN_HOLD: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
        (FUNC_IN == `CCA_FN_UPDOWN && seed != UP_DOWN_IN) |=> SUM_OUT == $past(OPA_IN))
        else $error("up/down pass wrong");

    // complementer with no borrow just inverts a
    AST_TWOS_PASS: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
        (FUNC_IN == `CCA_FN_TWOS && seed) |=> SUM_OUT == $past(~OPA_IN))
        else $error("twos pass wrong");

    // forced low seed makes the complementer negate a
    AST_TWOS_FORCE: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
        (FUNC_IN == `CCA_FN_TWOS && FORCE_LSB_IN) |=> SUM_OUT == $past(~OPA_IN + one_w))
        else $error("twos forced seed wrong");

    // chain carry pin seeds the adder when selected
    AST_SEED_CIN: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
        (FUNC_IN == `CCA_FN_ADD && SEED_SEL_IN == `CCA_SEED_CIN) |=>
        SUM_OUT == $past(ab_sum + {{(WIDTH-1){1'b0}}, CARRY_IN}))
        else $error("carry pin seed wrong");

    // input one seeds the adder when selected
    AST_SEED_IN1: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
        (FUNC_IN == `CCA_FN_ADD && SEED_SEL_IN == `CCA_SEED_IN1) |=>
        SUM_OUT == $past(ab_sum + {{(WIDTH-1){1'b0}}, SEED_IN1_IN}))
        else $error("input one seed wrong");

    // inverted input three seeds the adder when selected
    AST_SEED_INV3: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
        (FUNC_IN == `CCA_FN_ADD && SEED_SEL_IN == `CCA_SEED_INV3) |=>
        SUM_OUT == $past(ab_sum + {{(WIDTH-1){1'b0}}, ~ADD_SUB_IN}))
        else $error("inverted input three seed wrong");

    // constant seeds the adder when selected
    AST_SEED_CONST: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
        (FUNC_IN == `CCA_FN_ADD && SEED_SEL_IN == `CCA_SEED_CONST) |=>
        SUM_OUT == $past(ab_sum + {{(WIDTH-1){1'b0}}, SEED_CONST_IN}))
        else $error("constant seed wrong");

    COV_ADD_CARRY: cover property (@(posedge SYS_CLK_IN) FUNC_IN == `CCA_FN_ADD ##1 CARRY_OUT);
    COV_OVF:       cover property (@(posedge SYS_CLK_IN) FUNC_IN == `CCA_FN_ADD_OR_SUB_CELLS ##1 OVF_OUT);
    COV_DEC_WRAP:  cover property (@(posedge SYS_CLK_IN) FUNC_IN == `CCA_FN_DEC && OPA_IN == '0 && !seed);
    COV_TWOS:      cover property (@(posedge SYS_CLK_IN) FUNC_IN == `CCA_FN_TWOS);
    // down count through the base cell
    COV_DOWN:      cover property (@(posedge SYS_CLK_IN) FUNC_IN == `CCA_FN_UPDOWN && FORCE_LSB_IN && !UP_DOWN_IN);
endmodule

// ==== core/cca_carry_stage.sv ====
// one carry stage: mux between operand a and the incoming carry
module cca_carry_stage (
    input  wire logic                    a_in,
    input  wire logic                    b_in,
    input  wire logic                    cin_in,
    input  wire cca_pkg::cca_stage_cfg_s cfg_in,
    input  wire logic                    sum_inv_in,
    output logic                         sum_out,
    output logic                         cout_out
);
    logic b_eff;   // b after gate and polarity control
    // gate b before inverting it, so decrement sees all ones
    assign b_eff = (b_in & ~cfg_in.b_gate) ^ cfg_in.b_invert;
    // equal operands give a, different ones pass the carry
    assign cout_out = (a_in == b_eff) ? a_in : cin_in;
    // generator uses the same modified b, optional output inversion
    assign sum_out = a_in ^ b_eff ^ cin_in ^ sum_inv_in;
endmodule

// ==== core/cca_pkg.sv ====
package cca_pkg;
    // operation selected by the surrounding logic
    typedef logic [2:0] cca_fn_t;
    // carry stage configuration shared by every stage
    typedef struct packed {
        logic b_invert;   // polarity control of b
        logic b_gate;     // high forces b to zero
    } cca_stage_cfg_s;
    // outputs of the datapath
    typedef struct packed {
        logic sum_msb;
        logic carry;
        logic ovf;
    } cca_flags_s;
    // registered state of the top module
    typedef struct packed {
        logic [31:0] sum;
        logic        carry;
        logic        ovf;
        logic        msb_carry_in;
    } cca_state_s;
endpackage

// ==== core/cca_regs.svh ====
`ifndef CCA_REGS_SVH
`define CCA_REGS_SVH
// function codes
`define CCA_FN_ADD      3'h0
`define CCA_FN_SUB      3'h1
`define CCA_FN_ADD_OR_SUB_CELLS   3'h2
`define CCA_FN_INC      3'h3
`define CCA_FN_DEC      3'h4
`define CCA_FN_UPDOWN   3'h5
`define CCA_FN_TWOS     3'h6
// seed source codes for the least significant end
`define CCA_SEED_CIN    2'h0
`define CCA_SEED_IN1    2'h1
`define CCA_SEED_INV3   2'h2
`define CCA_SEED_CONST  2'h3
// default datapath width
`define CCA_WIDTH       8
`endif

// ==== core/cca_seed.sv ====
`include "cca_regs.svh"
// initialization cell at the least significant end
module cca_seed (
    input  wire logic       src_in,   // chain carry from another stage
    input  wire logic [1:0] sel_in,
    input  wire logic       in1_in,
    input  wire logic       in3_in,
    input  wire logic       const_in,
    output logic            seed_out
);
    // choose carry seed from chain carry, pin one, inverted pin three or constant
    always_comb begin
        unique case (sel_in)
            `CCA_SEED_IN1:  seed_out = in1_in;
            `CCA_SEED_INV3: seed_out = ~in3_in;
            `CCA_SEED_CONST: seed_out = const_in;
            `CCA_SEED_CIN:  seed_out = src_in;   // chain carry from another stage
        endcase
    end
endmodule

// ==== tb/cca_arith_unit_tb_top.sv ====
`include "cca_regs.svh"
// top of the bench: scenario tasks drive the unit and judge its results
module cca_arith_unit_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'h0;                       // system clock
    logic       rst = 1'h1;                       // async reset
    logic [7:0] opa = 8'h00, opb = 8'h00, sum;    // operands and result
    logic [2:0] func = 3'h0;                      // function select
    logic [1:0] ssel = 2'h0;                      // seed select
    logic       as = 1'h1, ud = 1'h1, cq = 1'h0;  // modes and requested carry
    logic       fol = 1'h0, in1 = 1'h0, cst = 1'h0, frc = 1'h0;
    logic       cin, cout, ovf;                   // chain carry and flags
    int         n_fail = 0;
    int         total_checks = 0;
    always #12.5 clk = ~clk;
    cca_arith_unit #(.WIDTH(8)) u_cca_arith_unit (.SYS_CLK_IN(clk), .SYS_RST_IN(rst), .OPA_IN(opa), .OPB_IN(opb),
        .FUNC_IN(func), .ADD_SUB_IN(as), .UP_DOWN_IN(ud), .SEED_SEL_IN(ssel), .CARRY_IN(cin), .SEED_IN1_IN(in1),
        .SEED_CONST_IN(cst), .FORCE_LSB_IN(frc), .SUM_OUT(sum), .CARRY_OUT(cout), .OVF_OUT(ovf));
    cca_user_model u_cca_user_model (.func_in(func), .add_sub_in(as), .up_down_in(ud), .carry_req_in(cq),
        .follow_op_in(fol), .carry_out(cin));
    // compare one value and count it
    task automatic check(input string nm, input logic [9:0] seen, input logic [9:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one operation: src is {follow, const, in1, carry}, m is the mode
    task automatic apply(input logic [2:0] fn, input logic [7:0] a, input logic [7:0] b, input logic m,
                         input logic [1:0] sel, input logic [3:0] src, input logic f, input string nm);
        logic       s;
        logic [7:0] be;
        logic [7:0] t;
        logic [8:0] full;
        s = sel == 2'h1 ? src[1] : sel == 2'h2 ? ~m : sel == 2'h3 ? src[2] : src[0];
        if (sel == 2'h0 && src[3] && fn == `CCA_FN_ADD_OR_SUB_CELLS) s = ~m;
        if (sel == 2'h0 && src[3] && fn == `CCA_FN_UPDOWN) s = m;
        if (f) begin
            case (fn)
                `CCA_FN_SUB, `CCA_FN_INC: s = 1'h1;
                `CCA_FN_DEC, `CCA_FN_TWOS: s = 1'h0;
                `CCA_FN_UPDOWN: s = m;
                `CCA_FN_ADD_OR_SUB_CELLS: s = ~m;
                default: ;
            endcase
        end
        case (fn)
            `CCA_FN_SUB: be = ~b;
            `CCA_FN_ADD_OR_SUB_CELLS: be = m ? b : ~b;
            `CCA_FN_INC: be = 8'h00;
            `CCA_FN_DEC, `CCA_FN_TWOS: be = 8'hFF;
            `CCA_FN_UPDOWN: be = m ? 8'h00 : 8'hFF;
            default: be = b;
        endcase
        full = {1'h0, a} + {1'h0, be} + {8'h00, s};
        t = {1'h0, a[6:0]} + {1'h0, be[6:0]} + {7'h00, s};
        @(posedge clk);
        {func, opa, opb, as, ud, ssel} <= {fn, a, b, m, m, sel};
        {fol, cst, in1, cq, frc} <= {src, f};
        @(posedge clk);
        #1;
        check(nm, {cout, ovf, sum}, {full[8], full[8] ^ t[7], fn == `CCA_FN_TWOS ? ~full[7:0] : full[7:0]});
    endtask
    // adds: generate, propagate, overflow, unused code
    task automatic t_add();
        apply(`CCA_FN_ADD, 8'h7F, 8'h01, 1'h1, 2'h0, 4'h0, 1'h0, "add_ovf");
        apply(`CCA_FN_ADD, 8'hFF, 8'h01, 1'h1, 2'h0, 4'h0, 1'h0, "add_cout");
        apply(`CCA_FN_ADD, 8'h55, 8'hAA, 1'h1, 2'h0, 4'h1, 1'h0, "add_prop");
        apply(`CCA_FN_ADD, 8'hC3, 8'hC3, 1'h1, 2'h0, 4'h0, 1'h1, "add_gen");
        apply(3'h7, 8'h80, 8'h80, 1'h0, 2'h0, 4'h1, 1'h1, "unused_code");
    endtask
    // subtracts with and without borrow
    task automatic t_sub();
        apply(`CCA_FN_SUB, 8'h10, 8'h03, 1'h1, 2'h0, 4'h1, 1'h0, "sub_nb");
        apply(`CCA_FN_SUB, 8'h10, 8'h03, 1'h1, 2'h0, 4'h0, 1'h0, "sub_b");
        apply(`CCA_FN_SUB, 8'h10, 8'h03, 1'h1, 2'h0, 4'h0, 1'h1, "sub_lsb");
        apply(`CCA_FN_SUB, 8'h80, 8'h01, 1'h1, 2'h0, 4'h1, 1'h0, "sub_ovf");
    endtask
    // adder/subtractor in both modes
    task automatic t_add_or_sub_cells();
        for (int i = 0; i < 2; i++) begin
            apply(`CCA_FN_ADD_OR_SUB_CELLS, 8'h5A, 8'h33, i[0], 2'h2, 4'h0, 1'h0, "as_sel");
            apply(`CCA_FN_ADD_OR_SUB_CELLS, 8'h5A, 8'h33, i[0], 2'h0, 4'h8, 1'h0, "as_user");
            apply(`CCA_FN_ADD_OR_SUB_CELLS, 8'h7F, 8'hFF, i[0], 2'h0, 4'h1, 1'h1, "as_lsb");
        end
    endtask
    // increment, decrement and up/down
    task automatic t_updown_cells();
        apply(`CCA_FN_INC, 8'hFF, 8'hA5, 1'h1, 2'h0, 4'h1, 1'h0, "inc");
        apply(`CCA_FN_INC, 8'h7F, 8'hA5, 1'h1, 2'h0, 4'h0, 1'h0, "inc_pass");
        apply(`CCA_FN_INC, 8'h12, 8'h00, 1'h1, 2'h0, 4'h0, 1'h1, "inc_seed");
        apply(`CCA_FN_DEC, 8'h00, 8'h5A, 1'h1, 2'h0, 4'h0, 1'h0, "dec");
        apply(`CCA_FN_DEC, 8'h00, 8'h5A, 1'h1, 2'h0, 4'h1, 1'h0, "dec_pass");
        apply(`CCA_FN_DEC, 8'h80, 8'h00, 1'h1, 2'h0, 4'h1, 1'h1, "dec_seed");
        for (int i = 0; i < 2; i++) begin
            apply(`CCA_FN_UPDOWN, 8'h80, 8'h3C, i[0], 2'h0, 4'h8, 1'h0, "ud_move");
            apply(`CCA_FN_UPDOWN, 8'h80, 8'h3C, i[0], 2'h2, 4'h0, 1'h0, "ud_pass");
            apply(`CCA_FN_UPDOWN, 8'hFF, 8'h3C, i[0], 2'h0, 4'h0, 1'h1, "ud_base");
        end
    endtask
    // every seed source with one source high at a time
    task automatic t_seeds();
        for (int s = 0; s < 4; s++) begin
            for (int k = 0; k < 3; k++) begin
                apply(`CCA_FN_ADD, 8'h40, 8'h01, 1'h0, s[1:0], 4'h1 << k, 1'h0, "seed");
            end
        end
    endtask
    // two's complement and pass-inverted
    task automatic t_twos();
        apply(`CCA_FN_TWOS, 8'h05, 8'hC0, 1'h1, 2'h0, 4'h0, 1'h0, "twos");
        apply(`CCA_FN_TWOS, 8'h00, 8'hC0, 1'h1, 2'h3, 4'h0, 1'h0, "twos_zero");
        apply(`CCA_FN_TWOS, 8'h80, 8'hC0, 1'h1, 2'h1, 4'h2, 1'h0, "twos_inv");
        apply(`CCA_FN_TWOS, 8'h01, 8'hC0, 1'h1, 2'h1, 4'h2, 1'h1, "twos_lsb");
    endtask
    // report counts and the verdict, then stop
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // main sequence: reset, then every scenario
    initial begin
        @(posedge clk);
        #1;
        check("reset_hold", {cout, ovf, sum}, 10'h000);
        @(posedge clk);
        rst <= 1'h0;
        t_add();
        t_sub();
        t_add_or_sub_cells();
        t_updown_cells();
        t_seeds();
        t_twos();
        end_of_test();
    end
    // watchdog: about ten times the expected run
    initial begin
        #25000;
        n_fail++;
        end_of_test();
    end
endmodule

// ==== tb/cca_user_model.sv ====
`include "cca_regs.svh"
// surrounding user logic that feeds the chain carry from an earlier stage
module cca_user_model (
    // requested operation
    input  wire logic [2:0] func_in,
    input  wire logic       add_sub_in,
    input  wire logic       up_down_in,
    // carry asked for by the bench, and follow-the-operation select
    input  wire logic       carry_req_in,
    input  wire logic       follow_op_in,
    // carry into the chain
    output logic            carry_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // choose a carry that suits the operation when asked to
    always_comb begin
        if (follow_op_in && func_in == `CCA_FN_ADD_OR_SUB_CELLS) begin
            carry_out = ~add_sub_in; // no carry when adding, no borrow when subtracting
        end else if (follow_op_in && func_in == `CCA_FN_UPDOWN) begin
            carry_out = up_down_in; // asserted carry or borrow so the count moves
        end else begin
            carry_out = carry_req_in; // plain carry from another stage
        end
    end
endmodule
